// ---- src/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
   // register indexes; byte address is index times four
   localparam logic [7:0] IDX_CONFIG       = 8'hE1;
   localparam logic [7:0] IDX_START_STATUS = 8'hE8;
   localparam logic [7:0] IDX_CMP_CTRL     = 8'hE2;
   localparam logic [7:0] IDX_ACQ_TIME     = 8'hF2;
   localparam logic [7:0] IDX_RESULT_HIGH  = 8'hC3;
   localparam logic [7:0] IDX_RESULT_LOW   = 8'hC2;
   localparam logic [7:0] IDX_THRESH_HIGH  = 8'hE4;
   localparam logic [7:0] IDX_THRESH_LOW   = 8'hE3;
   localparam int         IDX_LSB          = 2;
   localparam int         REG_ADDR_W       = 10;

   // reset values
   localparam logic [7:0] RST_CONFIG       = 8'h20;
   localparam logic [7:0] RST_ZERO         = 8'h00;
   localparam logic [7:0] CFG_WMASK        = 8'h73;

   // field positions
   localparam int CFG_ENABLE_BIT  = 0;
   localparam int CFG_EXT_SEL_BIT = 1;
   localparam int CFG_DIV_LSB     = 4;
   localparam int DIV_W           = 3;
   localparam int SS_DONE_BIT     = 7;
   localparam int SS_BUSY_BIT     = 6;
   localparam int CHAN_W          = 4;
   localparam int CC_POL_BIT      = 6;
   localparam int CC_EN_BIT       = 5;
   localparam int RESULT_W        = 10;
   localparam int RES_HIGH_LSB    = 2;
   localparam int RES_LOW_W       = 2;
   localparam int ACQ_W           = 8;
   localparam int NUM_PINS        = 8;
   localparam int NUM_INPUTS      = 9;

   localparam logic [CHAN_W-1:0] CHAN_BANDGAP  = 4'hF;
   localparam logic [CHAN_W-1:0] CHAN_LAST_PIN = 4'h7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_CONVERT} conv_state_t;
endpackage

// ---- src/adc_clk_div.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_clk_div
#(
   parameter int DIV_W = 3
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             run_in,
   input  wire logic [DIV_W-1:0] code_in,
   output logic                  tick_out
);
   localparam int CNT_W = (1 << DIV_W) - 1;

   generate
      if (DIV_W < 1)
         $error("DIV_W must be at least one");
   endgenerate

   logic [CNT_W-1:0] cnt_ff;
   wire  [CNT_W-1:0] limit = ~({CNT_W{1'b1}} << code_in);
   // >= so a code change mid-count cannot strand the counter
   wire              wrap  = (cnt_ff >= limit);

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_ff   <= '0;
         tick_out <= 1'b0;
      end
      else if (!run_in)
      begin
         cnt_ff   <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         cnt_ff   <= wrap ? '0 : cnt_ff + 1'b1;
         tick_out <= wrap;
      end
   end
endmodule
`default_nettype wire

// ---- src/adc_result_cmp.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_result_cmp
#(
   parameter int RES_W = 10
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             update_in,
   input  wire logic             enable_in,
   input  wire logic             polarity_in,
   input  wire logic [RES_W-1:0] result_in,
   input  wire logic [RES_W-1:0] threshold_in,
   output logic                  match_out
);
   generate
      if (RES_W < 1)
         $error("RES_W must be at least one");
   endgenerate

   wire at_or_above = (result_in >= threshold_in);
   wire nxt_match   = enable_in & (polarity_in ? !at_or_above : at_or_above);

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         match_out <= 1'b0;
      else if (update_in)
         match_out <= nxt_match;
   end
endmodule
`default_nettype wire

// ---- src/adc_conv_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - enable bit powers the converter when one, off when zero.
// - channel code 0-7 picks pin 0-7, code F the band-gap; others nothing.
// - with enable zero every analog input is disconnected.
// - writing one to start/busy starts a conversion; writing zero does nothing.
// - start/busy reads one while converting, cleared by hardware on completion.
// - completion sets the done flag and raises the interrupt request.
// - result bits 9..2 land in the high byte, 1..0 in the low byte.
// - done flag holds until software clears it; no new start while set.
// - with trigger select one, a falling pin edge also starts a conversion.
// - a pin-started conversion sets start/busy just like software.
// - starts during a conversion are silently dropped.
// - converter clock is system clock divided by two to the code; reset 010.
// - acquisition lasts acquisition count plus one converter clocks.
// - enabled comparator checks every completed result against the threshold.
// - comparator output bit updates at each completion per the polarity.
// - polarity zero means result >= threshold; polarity one means result < threshold.
// - acquisition count is an 8-bit read/write register reset to zero.
module adc_conv_ctrl
#(
   parameter int ADDR_W = 10
)
(
   input  wire logic                  CLK_SYS_IN,
   input  wire logic                  RESET_IN,
   input  wire logic [ADDR_W-1:0]     S_AXI_AWADDR_IN,
   input  wire logic                  S_AXI_AWVALID_IN,
   output logic                       S_AXI_AWREADY_OUT,
   input  wire logic [31:0]           S_AXI_WDATA_IN,
   input  wire logic [3:0]            S_AXI_WSTRB_IN,
   input  wire logic                  S_AXI_WVALID_IN,
   output logic                       S_AXI_WREADY_OUT,
   output logic [1:0]                 S_AXI_BRESP_OUT,
   output logic                       S_AXI_BVALID_OUT,
   input  wire logic                  S_AXI_BREADY_IN,
   input  wire logic [ADDR_W-1:0]     S_AXI_ARADDR_IN,
   input  wire logic                  S_AXI_ARVALID_IN,
   output logic                       S_AXI_ARREADY_OUT,
   output logic [31:0]                S_AXI_RDATA_OUT,
   output logic [1:0]                 S_AXI_RRESP_OUT,
   output logic                       S_AXI_RVALID_OUT,
   input  wire logic                  S_AXI_RREADY_IN,
   input  wire logic                  EXT_START_IN,
   input  wire logic                  ANALOG_DONE_IN,
   input  wire logic [adc_ctrl_pkg::RESULT_W-1:0] ANALOG_RESULT_IN,
   output logic                       CONV_POWER_OUT,
   output logic [adc_ctrl_pkg::NUM_INPUTS-1:0]    INPUT_CONNECT_OUT,
   output logic                       SAMPLE_OUT,
   output logic                       CONVERT_START_OUT,
   output logic                       CONV_CLK_TICK_OUT,
   output logic                       DONE_IRQ_OUT
);
   import adc_ctrl_pkg::*;

   generate
      if (ADDR_W < REG_ADDR_W)
         $error("ADDR_W too small for the register map");
   endgenerate

   // bus holding registers
   logic              aw_valid_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic              w_valid_ff;
   logic [7:0]        w_data_ff;
   logic              w_lane_ff;
   logic              bvalid_ff;
   logic [1:0]        bresp_ff;
   logic              rvalid_ff;
   logic [1:0]        rresp_ff;
   logic [7:0]        rdata_ff;

   // block registers
   logic [7:0]          config_ff;
   logic [CHAN_W-1:0]   chan_sel_ff;
   logic                done_flag_ff;
   logic                cmp_pol_ff;
   logic                cmp_en_ff;
   logic [ACQ_W-1:0]    acq_time_ff;
   logic [7:0]          thresh_high_ff;
   logic [RES_LOW_W-1:0] thresh_low_ff;
   logic [RESULT_W-1:0] result_ff;
   logic                ext_prev_ff;
   conv_state_t         state_ff;
   conv_state_t         nxt_state;
   logic [ACQ_W-1:0]    acq_cnt_ff;
   logic                convert_start_ff;
   logic                sample_ff;
   logic [NUM_INPUTS-1:0] connect_ff;
   logic                cmp_out;
   logic                tick;

   // write path: address and data may arrive in either order
   assign S_AXI_AWREADY_OUT = !aw_valid_ff && !bvalid_ff;
   assign S_AXI_WREADY_OUT  = !w_valid_ff && !bvalid_ff;
   wire        aw_take  = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
   wire        w_take   = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
   wire        do_write = aw_valid_ff && w_valid_ff && !bvalid_ff;
   wire [7:0]  wr_idx   = aw_addr_ff[IDX_LSB +: 8];
   wire        wr_en    = do_write && w_lane_ff;

   wire wr_cfg  = wr_en && (wr_idx == IDX_CONFIG);
   wire wr_ss   = wr_en && (wr_idx == IDX_START_STATUS);
   wire wr_cc   = wr_en && (wr_idx == IDX_CMP_CTRL);
   wire wr_acq  = wr_en && (wr_idx == IDX_ACQ_TIME);
   wire wr_th   = wr_en && (wr_idx == IDX_THRESH_HIGH);
   wire wr_tl   = wr_en && (wr_idx == IDX_THRESH_LOW);
   wire wr_ro   = (wr_idx == IDX_RESULT_HIGH) || (wr_idx == IDX_RESULT_LOW);
   wire wr_hit  = (wr_idx == IDX_CONFIG) || (wr_idx == IDX_START_STATUS)
               || (wr_idx == IDX_CMP_CTRL) || (wr_idx == IDX_ACQ_TIME)
               || (wr_idx == IDX_THRESH_HIGH) || (wr_idx == IDX_THRESH_LOW) || wr_ro;

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         aw_valid_ff <= 1'b0;
         aw_addr_ff  <= '0;
         w_valid_ff  <= 1'b0;
         w_data_ff   <= RST_ZERO;
         w_lane_ff   <= 1'b0;
         bvalid_ff   <= 1'b0;
         bresp_ff    <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_valid_ff <= 1'b1;
            aw_addr_ff  <= S_AXI_AWADDR_IN;
         end
         if (w_take)
         begin
            w_valid_ff <= 1'b1;
            w_data_ff  <= S_AXI_WDATA_IN[7:0];
            w_lane_ff  <= S_AXI_WSTRB_IN[0];
         end
         if (do_write)
         begin
            aw_valid_ff <= 1'b0;
            w_valid_ff  <= 1'b0;
            bvalid_ff   <= 1'b1;
            bresp_ff    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (S_AXI_BREADY_IN)
            bvalid_ff <= 1'b0;
      end
   end

   assign S_AXI_BVALID_OUT = bvalid_ff;
   assign S_AXI_BRESP_OUT  = bresp_ff;

   // read path
   wire       busy    = (state_ff != ST_IDLE);
   wire [7:0] rd_idx  = S_AXI_ARADDR_IN[IDX_LSB +: 8];
   wire       ar_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   wire [7:0] ss_view = {done_flag_ff, busy, 2'h0, chan_sel_ff};
   wire [7:0] cc_view = {1'h0, cmp_pol_ff, cmp_en_ff, cmp_out, 4'h0};
   wire [7:0] rd_byte =
        (rd_idx == IDX_CONFIG)       ? config_ff :
        (rd_idx == IDX_START_STATUS) ? ss_view :
        (rd_idx == IDX_CMP_CTRL)     ? cc_view :
        (rd_idx == IDX_ACQ_TIME)     ? acq_time_ff :
        (rd_idx == IDX_RESULT_HIGH)  ? result_ff[RESULT_W-1:RES_HIGH_LSB] :
        (rd_idx == IDX_RESULT_LOW)   ? {6'h00, result_ff[RES_LOW_W-1:0]} :
        (rd_idx == IDX_THRESH_HIGH)  ? thresh_high_ff :
        (rd_idx == IDX_THRESH_LOW)   ? {6'h00, thresh_low_ff} : RST_ZERO;
   wire       rd_hit  = (rd_idx == IDX_CONFIG) || (rd_idx == IDX_START_STATUS)
               || (rd_idx == IDX_CMP_CTRL) || (rd_idx == IDX_ACQ_TIME)
               || (rd_idx == IDX_RESULT_HIGH) || (rd_idx == IDX_RESULT_LOW)
               || (rd_idx == IDX_THRESH_HIGH) || (rd_idx == IDX_THRESH_LOW);

   assign S_AXI_ARREADY_OUT = !rvalid_ff;

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= RST_ZERO;
      end
      else if (ar_take)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rdata_ff  <= rd_byte;
      end
      else if (S_AXI_RREADY_IN)
         rvalid_ff <= 1'b0;
   end

   assign S_AXI_RVALID_OUT = rvalid_ff;
   assign S_AXI_RRESP_OUT  = rresp_ff;
   assign S_AXI_RDATA_OUT  = {24'h000000, rdata_ff};

   // start and completion
   wire ext_sel   = config_ff[CFG_EXT_SEL_BIT];
   wire ext_fall  = ext_prev_ff && !EXT_START_IN;
   wire sw_start  = wr_ss && w_data_ff[SS_BUSY_BIT];
   wire start_req = sw_start || (ext_sel && ext_fall);
   wire start_ok  = start_req && !busy && !done_flag_ff;
   wire complete  = (state_ff == ST_CONVERT) && ANALOG_DONE_IN;
   wire acq_last  = tick && (acq_cnt_ff == acq_time_ff);

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:    if (start_ok) nxt_state = ST_ACQUIRE;
         ST_ACQUIRE: if (acq_last) nxt_state = ST_CONVERT;
         ST_CONVERT: if (complete) nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         state_ff         <= ST_IDLE;
         acq_cnt_ff       <= '0;
         convert_start_ff <= 1'b0;
         sample_ff        <= 1'b0;
         ext_prev_ff      <= 1'b1;
      end
      else
      begin
         state_ff         <= nxt_state;
         ext_prev_ff      <= EXT_START_IN;
         convert_start_ff <= (state_ff == ST_ACQUIRE) && acq_last;
         sample_ff        <= (nxt_state == ST_ACQUIRE);
         if (state_ff != ST_ACQUIRE)
            acq_cnt_ff <= '0;
         else if (tick)
            acq_cnt_ff <= acq_cnt_ff + 1'b1;
      end
   end

   // software registers; hardware set of the done flag beats a clear
   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
      begin
         config_ff      <= RST_CONFIG;
         chan_sel_ff    <= '0;
         done_flag_ff   <= 1'b0;
         cmp_pol_ff     <= 1'b0;
         cmp_en_ff      <= 1'b0;
         acq_time_ff    <= RST_ZERO;
         thresh_high_ff <= RST_ZERO;
         thresh_low_ff  <= '0;
         result_ff      <= '0;
      end
      else
      begin
         if (wr_cfg)
            config_ff <= w_data_ff & CFG_WMASK;
         if (wr_ss)
            chan_sel_ff <= w_data_ff[CHAN_W-1:0];
         if (complete)
         begin
            done_flag_ff <= 1'b1;
            result_ff    <= ANALOG_RESULT_IN;
         end
         else if (wr_ss && !w_data_ff[SS_DONE_BIT])
            done_flag_ff <= 1'b0;
         if (wr_cc)
         begin
            cmp_pol_ff <= w_data_ff[CC_POL_BIT];
            cmp_en_ff  <= w_data_ff[CC_EN_BIT];
         end
         if (wr_acq)
            acq_time_ff <= w_data_ff;
         if (wr_th)
            thresh_high_ff <= w_data_ff;
         if (wr_tl)
            thresh_low_ff <= w_data_ff[RES_LOW_W-1:0];
      end
   end

   // input routing, one flop per analog line
   wire                  conv_en = config_ff[CFG_ENABLE_BIT];
   wire [NUM_INPUTS-1:0] nxt_connect;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++)
      begin : g_route
         if (gi < NUM_PINS)
            assign nxt_connect[gi] = conv_en && (chan_sel_ff == CHAN_W'(gi));
         else
            assign nxt_connect[gi] = conv_en && (chan_sel_ff == CHAN_BANDGAP);
      end
   endgenerate

   always_ff @(posedge CLK_SYS_IN or posedge RESET_IN)
   begin
      if (RESET_IN)
         connect_ff <= '0;
      else
         connect_ff <= nxt_connect;
   end

   // divider restarts each acquisition so its length is exact
   adc_clk_div #(.DIV_W(DIV_W)) u_div
   (
      .clk_in   (CLK_SYS_IN),
      .rst_in   (RESET_IN),
      .run_in   (state_ff == ST_ACQUIRE),
      .code_in  (config_ff[CFG_DIV_LSB +: DIV_W]),
      .tick_out (tick)
   );

   adc_result_cmp #(.RES_W(RESULT_W)) u_cmp
   (
      .clk_in       (CLK_SYS_IN),
      .rst_in       (RESET_IN),
      .update_in    (complete),
      .enable_in    (cmp_en_ff),
      .polarity_in  (cmp_pol_ff),
      .result_in    (ANALOG_RESULT_IN),
      .threshold_in ({thresh_high_ff, thresh_low_ff}),
      .match_out    (cmp_out)
   );

   assign CONV_POWER_OUT    = conv_en;
   assign INPUT_CONNECT_OUT = connect_ff;
   assign SAMPLE_OUT        = sample_ff;
   assign CONVERT_START_OUT = convert_start_ff;
   assign CONV_CLK_TICK_OUT = tick;
   assign DONE_IRQ_OUT      = done_flag_ff;

   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RESET_IN);

   power_follows_a: assert property (
      wr_cfg |=> CONV_POWER_OUT == $past(w_data_ff[CFG_ENABLE_BIT]))
      else $error("converter power does not follow enable bit");
   chan_route_a: assert property (
      (conv_en && chan_sel_ff <= CHAN_LAST_PIN && !wr_cfg && !wr_ss)
      |=> INPUT_CONNECT_OUT == (9'h001 << $past(chan_sel_ff)))
      else $error("wrong analog input routed");
   off_disconnect_a: assert property (
      !conv_en |=> INPUT_CONNECT_OUT == 9'h000)
      else $error("input connected while converter off");
   start_sets_busy_a: assert property (
      (start_ok && !RESET_IN) |=> ss_view[SS_BUSY_BIT] ##0 SAMPLE_OUT)
      else $error("accepted start did not set busy");
   busy_ignore_a: assert property (
      (state_ff == ST_CONVERT && !ANALOG_DONE_IN && start_req) |=> state_ff == ST_CONVERT)
      else $error("start during conversion disturbed it");
   done_blocks_a: assert property (
      (done_flag_ff && !busy && !(wr_ss && !w_data_ff[SS_DONE_BIT]))
      |=> !busy [*2])
      else $error("conversion started while done flag set");
   no_ext_start_a: assert property (
      (!busy && !ext_sel && !sw_start) |=> !busy)
      else $error("start without software while trigger select is zero");
   complete_update_a: assert property (
      complete |=> !busy && done_flag_ff && DONE_IRQ_OUT
                   && result_ff == $past(ANALOG_RESULT_IN))
      else $error("completion did not update all status together");
   acq_hold_a: assert property (
      (state_ff == ST_ACQUIRE && tick && acq_cnt_ff != acq_time_ff)
      |=> state_ff == ST_ACQUIRE)
      else $error("acquisition ended early");
   acq_end_a: assert property (
      (state_ff == ST_ACQUIRE && acq_last) |=> state_ff == ST_CONVERT && CONVERT_START_OUT)
      else $error("acquisition did not end on its last clock");
   div_full_rate_a: assert property (
      (state_ff == ST_ACQUIRE && $past(state_ff) == ST_ACQUIRE
       && config_ff[CFG_DIV_LSB +: DIV_W] == 3'h0 && $stable(config_ff)) |-> tick)
      else $error("divide-by-one gave no converter clock");
   cmp_ge_a: assert property (
      (complete && cmp_en_ff && !cmp_pol_ff
       && ANALOG_RESULT_IN >= {thresh_high_ff, thresh_low_ff}) |=> cmp_out)
      else $error("comparator missed result at or above threshold");
   cmp_lt_a: assert property (
      (complete && cmp_en_ff && cmp_pol_ff
       && ANALOG_RESULT_IN >= {thresh_high_ff, thresh_low_ff}) |=> !cmp_out)
      else $error("inverted comparator set on high result");

   sw_conv_c: cover property (sw_start && start_ok ##[1:600] complete);
   ext_conv_c: cover property (ext_sel && ext_fall && start_ok);
   cmp_hit_c: cover property (complete && cmp_en_ff ##1 cmp_out);
   set_beats_clear_c: cover property (complete && wr_ss && !w_data_ff[SS_DONE_BIT]);
endmodule
`default_nettype wire

// ---- verif/adc_analog_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module adc_analog_model
#(
   parameter int DELAY = 6
)
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       start_in,
   input  wire logic [9:0] value_in,
   output logic            done_out,
   output logic [9:0]      result_out
);
   // pins seen as pure analog inputs, no digital path modelled
   int cnt_ff;
   // result lines show the inverse outside the done cycle, so a stale capture is seen
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cnt_ff     <= 0;
         done_out   <= 1'b0;
         result_out <= 10'h000;
      end
      else
      begin
         done_out   <= (cnt_ff == 1);
         result_out <= (cnt_ff == 1) ? value_in : ~value_in;
         cnt_ff     <= start_in ? DELAY : ((cnt_ff > 0) ? cnt_ff - 1 : 0);
      end
   end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import adc_ctrl_pkg::*;
   logic        clk, rst, awv, wv, bry, arv, rry, ext, pdone;
   logic        awr, wrd, bv, arr, rv, pwr, smp, cst, tck, irq;
   logic [9:0]  awa, ara, pres, val;
   logic [31:0] wd, rdat, d;
   logic [1:0]  br, rr, r;
   logic [8:0]  con;
   int          n_errors = 0, checks_done = 0, cyc = 0, n_ticks = 0, gap = 0, last_t = 0;
   int          n_conv = 0;

   adc_conv_ctrl i_adc_conv_ctrl (.CLK_SYS_IN(clk), .RESET_IN(rst),
      .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
      .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
      .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
      .S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
      .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr),
      .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry), .EXT_START_IN(ext),
      .ANALOG_DONE_IN(pdone), .ANALOG_RESULT_IN(pres), .CONV_POWER_OUT(pwr),
      .INPUT_CONNECT_OUT(con), .SAMPLE_OUT(smp), .CONVERT_START_OUT(cst),
      .CONV_CLK_TICK_OUT(tck), .DONE_IRQ_OUT(irq));
   adc_analog_model i_adc_analog_model (.clk_in(clk), .rst_in(rst), .start_in(cst),
      .value_in(val), .done_out(pdone), .result_out(pres));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task print_verdict;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task wr(input logic [7:0] idx, input logic [7:0] v);
      logic ad, wdn;
      ad  = 1'b0;
      wdn = 1'b0;
      @(posedge clk);
      awa <= {idx, 2'b00};
      wd  <= {24'h0, v};
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= 1'b1;
      while (!(ad && wdn))
      begin
         @(negedge clk);
         ad  = ad | awr;
         wdn = wdn | wrd;
         @(posedge clk);
         awv <= !ad;
         wv  <= !wdn;
      end
      @(negedge clk);
      while (bv !== 1'b1) @(negedge clk);
      r = br;
      @(posedge clk);
      bry <= 1'b0;
   endtask

   task rd(input logic [7:0] idx);
      logic got;
      got = 1'b0;
      @(posedge clk);
      ara <= {idx, 2'b00};
      arv <= 1'b1;
      rry <= 1'b1;
      while (!got)
      begin
         @(negedge clk);
         got = arr;
         @(posedge clk);
         arv <= !got;
      end
      @(negedge clk);
      while (rv !== 1'b1) @(negedge clk);
      d = rdat;
      r = rr;
      @(posedge clk);
      rry <= 1'b0;
   endtask

   task rchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = RESP_OKAY);
      rd(idx);
      chk(d, {24'h0, exp});
      chk(r, er);
   endtask

   task wait_done;
      @(negedge clk);
      while (irq !== 1'b1) @(negedge clk);
   endtask

   task pulse_ext;
      @(posedge clk);
      ext <= 1'b0;
      repeat (3) @(posedge clk);
      ext <= 1'b1;
   endtask

   // tick spacing and start pulses watched where outputs are settled
   always @(negedge clk)
   begin
      cyc++;
      if (tck === 1'b1)
      begin
         gap    = cyc - last_t;
         last_t = cyc;
         n_ticks++;
      end
      if (cst === 1'b1)
         n_conv++;
      if (cyc > 20000)
      begin
         n_errors++;
         print_verdict;
      end
   end

   initial
   begin
      {rst, ext} = 2'b11;
      {awv, wv, bry, arv, rry} = 5'h00;
      {awa, ara, wd} = '0;
      val = 10'h2B7;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rchk(IDX_CONFIG, RST_CONFIG);
      rchk(IDX_START_STATUS, RST_ZERO);
      rchk(IDX_ACQ_TIME, RST_ZERO);
      rchk(8'h00, 8'h00, RESP_SLVERR);
      wr(8'h00, 8'hFF);
      chk(r, RESP_SLVERR);
      wr(IDX_ACQ_TIME, 8'hA5);
      rchk(IDX_ACQ_TIME, 8'hA5);
      wr(IDX_CONFIG, 8'h01);
      chk(pwr, 1'b1);
      for (int c = 0; c < 16; c++)
      begin
         wr(IDX_START_STATUS, 8'(c));
         repeat (2) @(negedge clk);
         chk(con, (c < 8) ? (9'h001 << c) : ((c == 15) ? 9'h100 : 9'h000));
      end
      wr(IDX_CONFIG, 8'h00);
      repeat (2) @(negedge clk);
      chk(pwr, 1'b0);
      chk(con, 9'h000);
      // divide by two, three acquisition clocks, threshold equal to the result
      wr(IDX_CONFIG, 8'h11);
      wr(IDX_ACQ_TIME, 8'h02); // acquisition count only changed while idle
      wr(IDX_THRESH_HIGH, 8'hAD);
      wr(IDX_THRESH_LOW, 8'h03);
      wr(IDX_CMP_CTRL, 8'h20);
      n_ticks = 0;
      wr(IDX_START_STATUS, 8'h43);
      rchk(IDX_START_STATUS, 8'h43);
      wait_done;
      chk(n_ticks, 3);
      chk(gap, 2);
      rchk(IDX_RESULT_HIGH, 8'hAD);
      rchk(IDX_RESULT_LOW, 8'h03);
      rchk(IDX_START_STATUS, 8'h83);
      rchk(IDX_CMP_CTRL, 8'h30);
      wr(IDX_START_STATUS, 8'hC3);
      rchk(IDX_START_STATUS, 8'h83);
      wr(IDX_START_STATUS, 8'h03);
      rchk(IDX_START_STATUS, 8'h03);
      chk(irq, 1'b0);
      // pin edge with trigger select off
      pulse_ext;
      repeat (4) @(negedge clk);
      chk(smp, 1'b0);
      val <= 10'h0F0;
      wr(IDX_CMP_CTRL, 8'h60);
      wr(IDX_CONFIG, 8'h13);
      n_conv = 0;
      pulse_ext;
      rchk(IDX_START_STATUS, 8'h43);
      pulse_ext;
      wait_done;
      wr(IDX_START_STATUS, 8'h03);
      repeat (30) @(negedge clk);
      chk(n_conv, 1);
      rchk(IDX_RESULT_HIGH, 8'h3C);
      rchk(IDX_CMP_CTRL, 8'h70);
      print_verdict;
   end
endmodule
`default_nettype wire
